// ---- rtl/tpw_timer8.sv ----
// Function
// - modes 1 and 5 count up then down
// - top is 0xFF or compare A
// - clear on up match, set on down
// - hold top one tick then reverse
// - overflow flag set at bottom
// - A toggle only with high mode bit
// - 510 tick period, prescale 1..1024
// - bottom gives low, max gives high
// - leaving max forces period-start transition
// - missed up match applied at bottom
// - fully synchronous, tick is enable
// - CTC and fast-A: flag and clear together
// - control A layout, reserved zero, reset zero
// - nonzero action overrides port pin
// - non-PWM action decode: off/toggle/clear/set
// - fast PWM match and top actions
// - phase correct action decode
// - compare equal top: act at top
// - mode encoding and compare update at top
// - high mode bit and tick select
// - output B same, toggle reserved
//
// The AXI4-Lite register port is this design's own decision.
`timescale 1ns/1ps
module tpw_timer8 (
  input logic clk_i,
  input logic rstn_i,
  input logic [tpw_pkg::AW-1:0] s_axi_awaddr,
  input logic s_axi_awvalid,
  output logic s_axi_awready,
  input logic [31:0] s_axi_wdata,
  input logic [3:0] s_axi_wstrb,
  input logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input logic s_axi_bready,
  input logic [tpw_pkg::AW-1:0] s_axi_araddr,
  input logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input logic s_axi_rready,
  input logic ext_tick_i,
  output logic wave_out_a_o,
  output logic wave_out_b_o,
  output logic wave_a_ovr_o,
  output logic wave_b_ovr_o
);
  import tpw_pkg::*;

  logic [7:0] ctrl_a_r;
  logic [3:0] ctrl_b_r;
  logic [7:0] cnt_r;
  logic [7:0] cnt_nxt;
  logic up_r;
  logic up_nxt;
  logic [7:0] ocra_buf_r;
  logic [7:0] ocrb_buf_r;
  logic [7:0] ocra_r;
  logic [7:0] ocrb_r;
  logic [2:0] flags_r;
  logic [2:0] flags_nxt;
  logic aw_pend_r;
  logic w_pend_r;
  logic [AW-1:0] awaddr_r;
  logic [7:0] wdata_r;
  logic wstrb_r;
  logic bvalid_r;
  logic [1:0] bresp_r;
  logic rvalid_r;
  logic [31:0] rdata_r;
  logic [1:0] rresp_r;
  logic tick;
  logic [31:0] rd_word;
  logic rd_ok;

  tpw_evt_if ev ();

  // write channel: address and data taken in either order
  assign s_axi_awready = ~aw_pend_r;
  assign s_axi_wready = ~w_pend_r;
  assign s_axi_bvalid = bvalid_r;
  assign s_axi_bresp = bresp_r;
  assign s_axi_arready = ~rvalid_r;
  assign s_axi_rvalid = rvalid_r;
  assign s_axi_rdata = rdata_r;
  assign s_axi_rresp = rresp_r;

  wire wr_go = aw_pend_r & w_pend_r & ~bvalid_r;
  wire wr_ok = (awaddr_r == OFS_CTRL_A) | (awaddr_r == OFS_CTRL_B) |
    (awaddr_r == OFS_COUNT) | (awaddr_r == OFS_CMP_A) |
    (awaddr_r == OFS_CMP_B) | (awaddr_r == OFS_FLAGS) | (awaddr_r == OFS_STATUS);
  wire wr_en = wr_go & wstrb_r;
  wire wr_ca = wr_en & (awaddr_r == OFS_CTRL_A);
  wire wr_cb = wr_en & (awaddr_r == OFS_CTRL_B);
  wire wr_cnt = wr_en & (awaddr_r == OFS_COUNT);
  wire wr_oa = wr_en & (awaddr_r == OFS_CMP_A);
  wire wr_ob = wr_en & (awaddr_r == OFS_CMP_B);
  wire wr_fl = wr_en & (awaddr_r == OFS_FLAGS);
  wire force_a = wr_cb & wdata_r[CB_FORCE_A];
  wire force_b = wr_cb & wdata_r[CB_FORCE_B];
  wire ar_go = s_axi_arvalid & ~rvalid_r;

  // mode decode
  wire [2:0] mode = {ctrl_b_r[CB_WSH], ctrl_a_r[1:0]};
  wire [1:0] act_a = ctrl_a_r[7:6];
  wire [1:0] act_b = ctrl_a_r[5:4];
  wire top_is_a = (mode == M_PC_OCR) | (mode == M_FAST_OCR);
  wire [7:0] top = top_is_a ? ocra_r : MAX;
  wire at_top = (cnt_r == top);
  wire at_bottom = (cnt_r == BOTTOM);
  wire match_a = (cnt_r == ocra_r);
  wire match_b = (cnt_r == ocrb_r);
  wire ocra_top = (ocra_r == top);
  wire ocrb_top = (ocrb_r == top);
  wire is_pwm = (ev.cls == TPW_FAST) | (ev.cls == TPW_PC);
  wire pwm_load = is_pwm & tick & at_top;

  assign ev.cls = (mode == M_PC_FF) | (mode == M_PC_OCR) ? TPW_PC :
    (mode == M_FAST_FF) | (mode == M_FAST_OCR) ? TPW_FAST :
    (mode == M_NORMAL) | (mode == M_CTC) ? TPW_NONPWM : TPW_OFF;
  assign ev.tick = tick;
  assign ev.up = up_r;
  assign ev.at_top = at_top;
  assign ev.at_bottom = at_bottom;
  assign ev.wsh = ctrl_b_r[CB_WSH];

  always_comb
  begin
    rd_ok = 1'b1;
    rd_word = 32'h0000_0000;
    unique case (s_axi_araddr)
      OFS_CTRL_A: rd_word[7:0] = ctrl_a_r;
      OFS_CTRL_B: rd_word[3:0] = ctrl_b_r;
      OFS_COUNT: rd_word[7:0] = cnt_r;
      OFS_CMP_A: rd_word[7:0] = ocra_buf_r;
      OFS_CMP_B: rd_word[7:0] = ocrb_buf_r;
      OFS_FLAGS: rd_word[2:0] = flags_r;
      OFS_STATUS: rd_word[2:0] = {up_r, wave_out_b_o, wave_out_a_o};
      default: rd_ok = 1'b0;
    endcase
  end

  // counter sequencing, only on the tick enable
  always_comb
  begin
    cnt_nxt = cnt_r;
    up_nxt = up_r;
    if (tick)
    begin
      unique case (ev.cls)
        TPW_NONPWM:
        begin
          up_nxt = 1'b1;
          if ((mode == M_CTC) & match_a) cnt_nxt = BOTTOM;
          else cnt_nxt = 8'(cnt_r + 8'h01);
        end
        TPW_FAST:
        begin
          up_nxt = 1'b1;
          if (at_top) cnt_nxt = BOTTOM;
          else cnt_nxt = 8'(cnt_r + 8'h01);
        end
        TPW_PC:
        begin
          if (up_r)
          begin
            if (at_top | (cnt_r == MAX))
            begin
              // top shown for this one tick, then reverse
              cnt_nxt = at_bottom ? BOTTOM : 8'(cnt_r - 8'h01);
              up_nxt = 1'b0;
            end
            else cnt_nxt = 8'(cnt_r + 8'h01);
          end
          else if (at_bottom)
          begin
            cnt_nxt = 8'(cnt_r + 8'h01);
            up_nxt = 1'b1;
          end
          else cnt_nxt = 8'(cnt_r - 8'h01);
        end
        TPW_OFF: cnt_nxt = cnt_r;
      endcase
    end
    if (wr_cnt) cnt_nxt = wdata_r;
  end

  // set wins over a write-one clear in the same cycle
  always_comb
  begin
    flags_nxt = flags_r & ~(wr_fl ? wdata_r[2:0] : 3'h0);
    if (tick)
    begin
      if (((ev.cls == TPW_NONPWM) & (cnt_r == MAX)) |
        ((ev.cls == TPW_FAST) & at_top) |
        ((ev.cls == TPW_PC) & at_bottom))
        flags_nxt[FL_OVF] = 1'b1;
      if (match_a) flags_nxt[FL_CMPA] = 1'b1;
      if (match_b) flags_nxt[FL_CMPB] = 1'b1;
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (!rstn_i)
    begin
      ctrl_a_r <= CA_RESET;
      ctrl_b_r <= 4'h0;
      cnt_r <= BOTTOM;
      up_r <= 1'b1;
      ocra_buf_r <= BOTTOM;
      ocrb_buf_r <= BOTTOM;
      ocra_r <= BOTTOM;
      ocrb_r <= BOTTOM;
      flags_r <= 3'h0;
    end
    else
    begin
      if (wr_ca) ctrl_a_r <= wdata_r & CA_WMASK;
      if (wr_cb) ctrl_b_r <= wdata_r[3:0];
      if (wr_oa) ocra_buf_r <= wdata_r;
      if (wr_ob) ocrb_buf_r <= wdata_r;
      // PWM compare values double buffered, loaded at top
      if (!is_pwm | pwm_load)
      begin
        ocra_r <= ocra_buf_r;
        ocrb_r <= ocrb_buf_r;
      end
      cnt_r <= cnt_nxt;
      up_r <= up_nxt;
      flags_r <= flags_nxt;
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (!rstn_i)
    begin
      aw_pend_r <= 1'b0;
      w_pend_r <= 1'b0;
      awaddr_r <= '0;
      wdata_r <= 8'h00;
      wstrb_r <= 1'b0;
      bvalid_r <= 1'b0;
      bresp_r <= RESP_OKAY;
      rvalid_r <= 1'b0;
      rdata_r <= 32'h0000_0000;
      rresp_r <= RESP_OKAY;
    end
    else
    begin
      if (s_axi_awvalid & ~aw_pend_r)
      begin
        aw_pend_r <= 1'b1;
        awaddr_r <= s_axi_awaddr;
      end
      if (s_axi_wvalid & ~w_pend_r)
      begin
        w_pend_r <= 1'b1;
        wdata_r <= s_axi_wdata[7:0];
        wstrb_r <= s_axi_wstrb[0];
      end
      if (wr_go)
      begin
        aw_pend_r <= 1'b0;
        w_pend_r <= 1'b0;
        bvalid_r <= 1'b1;
        bresp_r <= wr_ok ? RESP_OKAY : RESP_SLVERR;
      end
      else if (s_axi_bready) bvalid_r <= 1'b0;
      if (ar_go)
      begin
        rvalid_r <= 1'b1;
        rdata_r <= rd_word;
        rresp_r <= rd_ok ? RESP_OKAY : RESP_SLVERR;
      end
      else if (s_axi_rready) rvalid_r <= 1'b0;
    end
  end

  tpw_prescaler u_presc (
    .clk_i(clk_i),
    .rstn_i(rstn_i),
    .sel_i(ctrl_b_r[2:0]),
    .ext_pin_i(ext_tick_i),
    .tick_o(tick)
  );

  tpw_wave #(.IS_A(1'b1)) u_wave_a (
    .clk_i(clk_i),
    .rstn_i(rstn_i),
    .ev(ev),
    .action_i(act_a),
    .match_i(match_a),
    .ocr_top_i(ocra_top),
    .force_i(force_a),
    .wave_o(wave_out_a_o),
    .connect_o(wave_a_ovr_o)
  );

  tpw_wave #(.IS_A(1'b0)) u_wave_b (
    .clk_i(clk_i),
    .rstn_i(rstn_i),
    .ev(ev),
    .action_i(act_b),
    .match_i(match_b),
    .ocr_top_i(ocrb_top),
    .force_i(force_b),
    .wave_o(wave_out_b_o),
    .connect_o(wave_b_ovr_o)
  );

  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!rstn_i);

  wire pc = (ev.cls == TPW_PC);

  chk_pc_top_hold: assert property (
    pc & tick & up_r & at_top & ~at_bottom & ~wr_cnt |=> ~up_r && cnt_r == 8'($past(top) - 8'h01))
    else $error("top not held one tick");
  chk_pc_bot_turn: assert property (
    pc & tick & ~up_r & at_bottom & ~wr_cnt |=> up_r && cnt_r == 8'h01)
    else $error("no reversal at bottom");
  chk_pc_down_dec: assert property (
    pc & tick & ~up_r & ~at_bottom & ~wr_cnt |=> cnt_r == 8'($past(cnt_r) - 8'h01))
    else $error("down count not decrementing");
  chk_pc_ovf_set: assert property (
    pc & tick & at_bottom |=> flags_r[FL_OVF])
    else $error("overflow flag missed at bottom");
  chk_cmpb_flag: assert property (
    tick & match_b |=> flags_r[FL_CMPB])
    else $error("compare B flag missed");
  chk_ctc_clear: assert property (
    (mode == M_CTC) & tick & match_a & ~wr_cnt |=> cnt_r == BOTTOM && flags_r[FL_CMPA])
    else $error("ctc clear and flag not together");
  chk_tick_enable: assert property (
    ~tick & ~wr_cnt |=> $stable(cnt_r))
    else $error("count moved without tick");
  chk_top_fixed: assert property (
    (mode == M_PC_FF) |-> top == MAX)
    else $error("wrong top in mode 1");
  chk_ctrl_rsvd: assert property (
    ctrl_a_r[3:2] == 2'b00)
    else $error("reserved control bits set");
  chk_ovr_b_tog: assert property (
    is_pwm & (act_b == 2'b01) |-> ~wave_b_ovr_o)
    else $error("B toggle not reserved in PWM");
  chk_pc_low_hold: assert property (
    pc & (act_a == 2'b10) & (ocra_r == BOTTOM) & ~wave_out_a_o & ~wr_ca & ~wr_cb
    |=> ~wave_out_a_o)
    else $error("zero duty output went high");

  cov_pc_turn: cover property (pc & tick & up_r & at_top);
  cov_ctc_wrap: cover property ((mode == M_CTC) & tick & match_a);
  cov_pc_wave: cover property (pc & wave_a_ovr_o & $rose(wave_out_a_o));
endmodule

// ---- rtl/tpw_pkg.sv ----
package tpw_pkg;
  localparam int AW = 8;
  localparam logic [7:0] OFS_CTRL_A = 8'h30;
  localparam logic [7:0] OFS_CTRL_B = 8'h34;
  localparam logic [7:0] OFS_COUNT = 8'h38;
  localparam logic [7:0] OFS_CMP_A = 8'h3C;
  localparam logic [7:0] OFS_CMP_B = 8'h40;
  localparam logic [7:0] OFS_FLAGS = 8'h44;
  localparam logic [7:0] OFS_STATUS = 8'h48;
  localparam int CA_ACT_A = 6;
  localparam int CA_ACT_B = 4;
  localparam logic [7:0] CA_WMASK = 8'hF3;
  localparam logic [7:0] CA_RESET = 8'h00;
  localparam int CB_FORCE_A = 7;
  localparam int CB_FORCE_B = 6;
  localparam int CB_WSH = 3;
  localparam int FL_OVF = 0;
  localparam int FL_CMPA = 1;
  localparam int FL_CMPB = 2;
  localparam logic [7:0] BOTTOM = 8'h00;
  localparam logic [7:0] MAX = 8'hFF;
  localparam logic [2:0] M_NORMAL = 3'h0;
  localparam logic [2:0] M_PC_FF = 3'h1;
  localparam logic [2:0] M_CTC = 3'h2;
  localparam logic [2:0] M_FAST_FF = 3'h3;
  localparam logic [2:0] M_PC_OCR = 3'h5;
  localparam logic [2:0] M_FAST_OCR = 3'h7;
  localparam int PC_PERIOD_TICKS = 510;
  localparam logic [9:0] PS_M8 = 10'h007;
  localparam logic [9:0] PS_M64 = 10'h03F;
  localparam logic [9:0] PS_M256 = 10'h0FF;
  localparam logic [9:0] PS_M1024 = 10'h3FF;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  typedef enum logic [1:0] {
    TPW_NONPWM = 2'b00,
    TPW_FAST = 2'b01,
    TPW_PC = 2'b10,
    TPW_OFF = 2'b11
  } tpw_class_t;
endpackage

// ---- rtl/tpw_evt_if.sv ----
`timescale 1ns/1ps
interface tpw_evt_if;
  logic tick;
  logic up;
  logic at_top;
  logic at_bottom;
  logic wsh;
  tpw_pkg::tpw_class_t cls;
  modport src (output tick, up, at_top, at_bottom, wsh, cls);
  modport dst (input tick, up, at_top, at_bottom, wsh, cls);
endinterface

// ---- rtl/tpw_prescaler.sv ----
`timescale 1ns/1ps
module tpw_prescaler (
  input logic clk_i,
  input logic rstn_i,
  input logic [2:0] sel_i,
  input logic ext_pin_i,
  output logic tick_o
);
  import tpw_pkg::*;
  logic [9:0] div_r;
  logic s1_r;
  logic s2_r;
  logic s3_r;

  function automatic logic div_hit(input logic [9:0] d, input logic [9:0] m);
    return (d & m) == m;
  endfunction

  always_ff @(posedge clk_i)
  begin
    if (!rstn_i)
    begin
      div_r <= 10'h000;
      s1_r <= 1'b0;
      s2_r <= 1'b0;
      s3_r <= 1'b0;
    end
    else
    begin
      div_r <= 10'(div_r + 10'h001);
      s1_r <= ext_pin_i;
      s2_r <= s1_r;
      s3_r <= s2_r;
    end
  end

  // tick is a clock enable only, never a clock
  always_comb
  begin
    unique case (sel_i)
      3'h0: tick_o = 1'b0;
      3'h1: tick_o = 1'b1;
      3'h2: tick_o = div_hit(div_r, PS_M8);
      3'h3: tick_o = div_hit(div_r, PS_M64);
      3'h4: tick_o = div_hit(div_r, PS_M256);
      3'h5: tick_o = div_hit(div_r, PS_M1024);
      3'h6: tick_o = s3_r & ~s2_r;
      3'h7: tick_o = s2_r & ~s3_r;
    endcase
  end
endmodule

// ---- rtl/tpw_wave.sv ----
`timescale 1ns/1ps
module tpw_wave #(
  parameter bit IS_A = 1'b1
) (
  input logic clk_i,
  input logic rstn_i,
  tpw_evt_if.dst ev,
  input logic [1:0] action_i,
  input logic match_i,
  input logic ocr_top_i,
  input logic force_i,
  output logic wave_o,
  output logic connect_o
);
  import tpw_pkg::*;
  logic wave_r;
  logic wave_nxt;
  logic up_seen_r;
  logic up_seen_nxt;
  wire toggle_ok = (ev.cls == TPW_NONPWM) | (IS_A & ev.wsh);
  wire is_tog = (action_i == 2'b01);
  // override only when action nonzero and not a reserved toggle
  assign connect_o = (action_i != 2'b00) & ~(is_tog & ~toggle_ok);
  assign wave_o = wave_r;
  wire hit_val = is_tog ? ~wave_r : action_i[0];
  wire up_val = action_i[0];
  wire dn_val = ~action_i[0];

  always_comb
  begin
    wave_nxt = wave_r;
    up_seen_nxt = up_seen_r;
    if (force_i & connect_o & (ev.cls == TPW_NONPWM))
      wave_nxt = hit_val;
    else if (ev.tick & connect_o)
    begin
      unique case (ev.cls)
        TPW_NONPWM: if (match_i) wave_nxt = hit_val;
        TPW_FAST:
        begin
          if (is_tog)
          begin
            if (match_i) wave_nxt = ~wave_r;
          end
          else if (ev.at_top) wave_nxt = ~action_i[0];
          else if (match_i & ~ocr_top_i) wave_nxt = action_i[0];
        end
        TPW_PC:
        begin
          if (is_tog)
          begin
            if (match_i) wave_nxt = ~wave_r;
          end
          else if (ev.at_bottom)
          begin
            // missed up match applied at period start keeps symmetry
            if (match_i | (~up_seen_r & ~ocr_top_i)) wave_nxt = up_val;
            up_seen_nxt = match_i;
          end
          else if (ev.at_top & ocr_top_i) wave_nxt = dn_val;
          else if (match_i & ev.up)
          begin
            wave_nxt = up_val;
            up_seen_nxt = 1'b1;
          end
          else if (match_i) wave_nxt = dn_val;
        end
        TPW_OFF: wave_nxt = wave_r;
      endcase
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (!rstn_i)
    begin
      wave_r <= 1'b0;
      up_seen_r <= 1'b0;
    end
    else
    begin
      wave_r <= wave_nxt;
      up_seen_r <= up_seen_nxt;
    end
  end
endmodule

// ---- verif/tpw_pin_model.sv ----
`timescale 1ns/1ps
module tpw_pin_model (
  input wire logic wave_i,
  input wire logic ovr_i,
  input wire logic dir_i,
  input wire logic port_i,
  output logic pin_o
);
  // pull-up holds the pin high while software leaves the driver off
  assign pin_o = !dir_i ? 1'h1 : (ovr_i ? wave_i : port_i);
endmodule

// ---- verif/timer8_phase_correct_pwm_bench.sv ----
`timescale 1ns/1ps
module timer8_phase_correct_pwm_bench;
  import tpw_pkg::*;
  typedef struct {string nm; logic [31:0] d; logic [1:0] r;} tpw_note_t;
  logic clk_i = 1'h0;
  logic rstn_i = 1'h0;
  logic [7:0] awaddr = 8'h00;
  logic [7:0] araddr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic awvalid = 1'h0;
  logic wvalid = 1'h0;
  logic bready = 1'h0;
  logic arvalid = 1'h0;
  logic rready = 1'h0;
  logic dir = 1'h1;
  logic port = 1'h1;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  logic wave_a, wave_b, ovr_a, ovr_b, pin_a, pin_b;
  int num_errors = 0;
  int compares = 0;
  tpw_note_t notes[$];

  always #25 clk_i = ~clk_i;

  tpw_timer8 dut (
    .clk_i(clk_i), .rstn_i(rstn_i),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .ext_tick_i(1'h0), .wave_out_a_o(wave_a), .wave_out_b_o(wave_b),
    .wave_a_ovr_o(ovr_a), .wave_b_ovr_o(ovr_b)
  );
  tpw_pin_model pa (.wave_i(wave_a), .ovr_i(ovr_a), .dir_i(dir), .port_i(port), .pin_o(pin_a));
  tpw_pin_model pb (.wave_i(wave_b), .ovr_i(ovr_b), .dir_i(dir), .port_i(port), .pin_o(pin_b));

  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string nm);
    compares++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("FAIL %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic finish_test();
    if (num_errors == 0 && compares > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  // handshakes are judged at the falling edge, where every signal has settled
  always @(negedge clk_i)
  begin
    tpw_note_t n;
    if ((bvalid && bready) || (rvalid && rready))
    begin
      n = notes.pop_front();
      check({30'h0, bvalid ? bresp : rresp}, {30'h0, n.r}, n.nm);
      if (rvalid)
        check(rdata, n.d, n.nm);
    end
  end

  task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [1:0] r = RESP_OKAY);
    bit aw_hs, w_hs, b_hs;
    notes.push_back('{$sformatf("write %h", a), 32'h0, r});
    @(posedge clk_i);
    awaddr <= a;
    wdata <= {24'h0, d};
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    bready <= 1'h1;
    do
    begin
      @(negedge clk_i);
      aw_hs = awvalid && awready;
      w_hs = wvalid && wready;
      b_hs = bvalid && bready;
      @(posedge clk_i);
      if (aw_hs) awvalid <= 1'h0;
      if (w_hs) wvalid <= 1'h0;
    end while (!b_hs);
    bready <= 1'h0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] d, input logic [1:0] r = RESP_OKAY);
    bit ar_hs, r_hs;
    notes.push_back('{$sformatf("read %h", a), {24'h0, d}, r});
    @(posedge clk_i);
    araddr <= a;
    arvalid <= 1'h1;
    rready <= 1'h1;
    do
    begin
      @(negedge clk_i);
      ar_hs = arvalid && arready;
      r_hs = rvalid && rready;
      @(posedge clk_i);
      if (ar_hs) arvalid <= 1'h0;
    end while (!r_hs);
    rready <= 1'h0;
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge clk_i);
  endtask

  // high time over a window is independent of where the window starts
  task automatic meas(input bit b, input int win, input int exp);
    int h = 0;
    repeat (win)
    begin
      @(negedge clk_i);
      if ((b ? pin_b : pin_a) === 1'h1) h++;
      // an unknown level must never pass as low
      else if ((b ? pin_b : pin_a) !== 1'h0) h += win;
    end
    check(h, exp, b ? "pin b high time" : "pin a high time");
  endtask

  initial
  begin
    int c;
    logic [7:0] v;
    void'($urandom(56));
    cyc(16);
    rstn_i <= 1'h1;
    rd(OFS_CTRL_A, 8'h00);
    wr(OFS_CTRL_A, 8'hFF);
    rd(OFS_CTRL_A, 8'hF3);
    wr(8'h4C, 8'h55, RESP_SLVERR);
    rd(8'h4C, 8'h00, RESP_SLVERR);
    wr(OFS_CMP_A, 8'h09);
    wr(OFS_CMP_B, 8'hF0);
    wr(OFS_CTRL_B, 8'h01);
    for (int k = 3; k >= 0; k--)
    begin
      wr(OFS_CTRL_A, {k[1:0], 6'h02});
      cyc(40);
      check(ovr_a, k != 0, "override a");
      if (k == 1)
        meas(0, 20, 10);
      else
        check(pin_a, k != 2, "pin a level");
    end
    wr(OFS_FLAGS, 8'h07);
    cyc(12);
    rd(OFS_FLAGS, 8'h02);
    c = $urandom_range(254, 1);
    wr(OFS_CMP_A, c[7:0]);
    wr(OFS_CMP_B, 8'h40);
    wr(OFS_CTRL_A, 8'hB3);
    cyc(600);
    meas(0, 256, c + 1);
    meas(1, 256, 191);
    wr(OFS_CTRL_A, 8'hB1);
    // from max through a random value to bottom: symmetry transitions included
    for (int i = 0; i < 3; i++)
    begin
      v = (i == 0) ? 8'hFF : ((i == 1) ? c[7:0] : 8'h00);
      wr(OFS_CMP_A, v);
      cyc(1100);
      meas(0, 510, 2 * v);
    end
    meas(1, 510, 382);
    wr(OFS_FLAGS, 8'h07);
    cyc(520);
    rd(OFS_FLAGS, 8'h07);
    wr(OFS_CMP_A, 8'h64);
    wr(OFS_CMP_B, 8'h20);
    wr(OFS_CTRL_B, 8'h09);
    wr(OFS_CTRL_A, 8'h61);
    cyc(1000);
    meas(0, 400, 200);
    meas(1, 200, 64);
    wr(OFS_CTRL_A, 8'hB1);
    wr(OFS_CTRL_B, 8'h02);
    wr(OFS_CMP_A, 8'h20);
    cyc(8200);
    meas(0, 4080, 512);
    // B toggle is reserved in PWM, so the port keeps the pin
    wr(OFS_CTRL_A, 8'h91);
    check(ovr_b, 1'h0, "override b");
    check(pin_b, port, "pin b port");
    // stopped counter holds a written count; normal mode then wraps
    wr(OFS_CTRL_B, 8'h00);
    wr(OFS_CTRL_A, 8'hE0);
    wr(OFS_COUNT, 8'hFE);
    rd(OFS_COUNT, 8'hFE);
    wr(OFS_FLAGS, 8'h07);
    wr(OFS_CTRL_B, 8'hC1);
    cyc(4);
    rd(OFS_FLAGS, 8'h01);
    rd(OFS_CTRL_B, 8'h01);
    rd(OFS_STATUS, 8'h05);
    finish_test();
  end

  initial
  begin
    #(60000 * 50);
    num_errors++;
    finish_test();
  end
endmodule
